// *** design/pfsc_pkg.sv ***
// Purpose: shared constants for the pulse-width fault/soft-start block
// Assumes: pclk at 10 MHz; analog levels quantised to 20 mV steps
// Notes:   times are given in ns and turned into cycle counts here
package pfsc_pkg;
  localparam int CNT_W         = 10;
  localparam int LVL_W         = 8;
  localparam int CLK_PERIOD_NS = 100;
  // frequency generator period and its rising-edge phase
  localparam int FG_PERIOD_NS  = 10000;
  localparam int FG_RISE_NS    = 1000;
  // sync switchover delay, loss-of-sync timeout, settling time
  localparam int SW_DELAY_NS   = 50000;
  localparam int SYNC_LOSS_NS  = 30000;
  localparam int SETTLE_NS     = 40000;
  localparam logic [CNT_W-1:0] FG_PERIOD_CYC =
    CNT_W'(FG_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FG_HALF_CYC   =
    CNT_W'(FG_PERIOD_NS / CLK_PERIOD_NS / 2);
  // least time: round up
  localparam logic [CNT_W-1:0] FG_RISE_CYC   =
    CNT_W'((FG_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SW_DELAY_CYC  =
    CNT_W'(SW_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SYNC_LOSS_CYC =
    CNT_W'(SYNC_LOSS_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETTLE_CYC    =
    CNT_W'(SETTLE_NS / CLK_PERIOD_NS);
  // analog levels in mV and as codes
  localparam int LVL_LSB_MV    = 20;
  localparam int RESTART_MV    = 1500;
  localparam int RAMP_MIN_MV   = 1800;
  localparam int SS_MAX_MV     = 5000;
  localparam logic [LVL_W-1:0] RESTART_LVL  =
    LVL_W'(RESTART_MV / LVL_LSB_MV);
  localparam logic [LVL_W-1:0] RAMP_MIN_LVL =
    LVL_W'(RAMP_MIN_MV / LVL_LSB_MV);
  localparam logic [LVL_W-1:0] SS_MAX_LVL   =
    LVL_W'(SS_MAX_MV / LVL_LSB_MV);
  localparam logic [LVL_W-1:0] SS_DIS_STEP  = 8'h04;
  // register map
  localparam logic [7:0] OFS_DUTY   = 8'h00;
  localparam logic [7:0] OFS_SSDIV  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [LVL_W-1:0] DUTY_RST  = 8'h80;
  localparam logic [LVL_W-1:0] SSDIV_RST = 8'h10;
  // status field positions
  localparam int ST_SUPPLY  = 0;
  localparam int ST_FAULTOK = 1;
  localparam int ST_PULSE   = 2;
  localparam int ST_EXT     = 3;
  localparam int ST_SETTLED = 4;
  localparam int ST_GATE    = 5;
  localparam int ST_FAULT   = 6;
  localparam int ST_SS_LSB  = 8;
  // synchronised pin vector positions
  localparam int NPIN        = 10;
  localparam int PIN_VS_ON   = 0;
  localparam int PIN_VS_OFF  = 1;
  localparam int PIN_OV      = 2;
  localparam int PIN_UV      = 3;
  localparam int PIN_OCF     = 4;
  localparam int PIN_CM      = 5;
  localparam int PIN_OCUT    = 6;
  localparam int PIN_OMIT    = 7;
  localparam int PIN_SKIP    = 8;
  localparam int PIN_SYNC    = 9;
endpackage

// *** design/pfsc_sync2.sv ***
// Purpose: two-flop synchroniser for a vector of pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pfsc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          meta_r[i] <= din[i];
          dout[i]   <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// *** design/pfsc_clksel.sv ***
// Purpose: internal/external timing selection from sync activity
// Assumes: sync_edge is a one-cycle pulse per transition on sync_in
// Notes:   settled stays low for a settling time after each switch
`timescale 1ns/1ps
module pfsc_clksel
  import pfsc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_edge,
  output logic      ext_mode,
  output logic      settled
);
  import pfsc_pkg::*;
  logic [CNT_W-1:0] idle_r;
  logic [CNT_W-1:0] act_r;
  logic [CNT_W-1:0] settle_r;
  logic             idle_full;
  logic             switch_now;

  assign idle_full  = (idle_r == SYNC_LOSS_CYC);
  assign switch_now = ext_mode ? idle_full : (act_r == SW_DELAY_CYC);
  assign settled    = (settle_r == SETTLE_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= SYNC_LOSS_CYC;
    end else if (sync_edge) begin
      idle_r <= '0;
    end else if (!idle_full) begin
      idle_r <= idle_r + 1'b1;
    end
  end

  // activity must last the switchover delay before external timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= '0;
    end else if (idle_full) begin
      act_r <= '0;
    end else if (act_r != SW_DELAY_CYC) begin
      act_r <= act_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode <= 1'b0;
    end else if (switch_now) begin
      ext_mode <= !ext_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= SETTLE_CYC;
    end else if (switch_now) begin
      settle_r <= '0;
    end else if (!settled) begin
      settle_r <= settle_r + 1'b1;
    end
  end
endmodule

// *** design/pfsc_top.sv ***
// Purpose: gate drive pulse control with fault latch and soft start
// Assumes: comparator results arrive as asynchronous digital pins
// Notes:   levels are 8-bit codes of 20 mV; APB slave, zero wait
`timescale 1ns/1ps
// Notes on behaviour
// - gate output stays off until supply rises above the turn-on level
// - supply-valid drops only below the lower turn-off level; gate low
// - each generator falling edge sets the pulse latch unless cleared
// - set pulse latch allows gate; duty, current, cutoff, omit clear it
// - duty compare uses lower reference; ramp above it clears pulse
// - restart request to fault latch while soft start is below 1.5 V
// - fault latch ignores set while any fault is present
// - any fault clears fault latch and forces gate low at once
// - after faults end duty returns gradually through soft start
// - gate re-enabled after fault only while pulse latch is high
// - overcurrent cutoff clears pulse latch, ending pulse early
// - pulse skip with omission overcurrent suppresses whole pulses
// - soft start starts at zero and rises only without fault
// - on fault soft start discharges toward zero, gate off at once
// - below 1.5 V soft start requests set unless a fault clears
// - duty follows smaller of soft start and reference; zero below 1.8 V
// - ramp runs at generator frequency, restarted by it
// - slave gate runs in antiphase to the master gate
// - no sync transitions means internal frequency generator timing
// - sync activity switches to external timing after a delay, and back
// - settling interval after switchover is flagged to the user
// - gate output active high, width varies within each period
// - generator falling phase bounds the longest high time
// - generator rising phase bounds the shortest low time
module pfsc_top
  import pfsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vs_above_on,
  input  wire logic        vs_above_off,
  input  wire logic        overvoltage_detector,
  input  wire logic        undervoltage_detector,
  input  wire logic        overcurrent_fault,
  input  wire logic        current_mode_comparator,
  input  wire logic        overcurrent_cutoff,
  input  wire logic        omission_overcurrent_comparator,
  input  wire logic        pulse_skip_input,
  input  wire logic        sync_in,
  output logic             gate_drive_out,
  output logic             sync_out,
  output logic             timing_ext,
  output logic             timing_settled
);
  import pfsc_pkg::*;

  logic [NPIN-1:0]  pin_raw;
  logic [NPIN-1:0]  pin_s;
  logic             sync_d_r;
  logic             sync_fall;
  logic             ext_mode;
  logic             settled;
  logic [CNT_W-1:0] fg_cnt_r;
  logic             fg_rise_ph;
  logic             fg_fall;
  logic             fg_wrap;
  logic [LVL_W-1:0] ramp_r;
  logic [LVL_W-1:0] duty_ref_r;
  logic [LVL_W-1:0] ss_div_cfg_r;
  logic [LVL_W-1:0] ss_div_r;
  logic [LVL_W-1:0] ss_level_r;
  logic [LVL_W-1:0] duty_lim;
  logic             duty_clr;
  logic             omit_clr;
  logic             pulse_clr;
  logic             pulse_r;
  logic             supply_ok_r;
  logic             fault_any;
  logic             fault_ok_r;
  logic             restart_req;
  logic             ss_dis;
  logic             gate_nxt;
  logic             apb_setup;
  logic             apb_wr;
  logic             addr_hit;
  logic [31:0]      rd_val;

  // every comparator pin crosses two flops before use
  assign pin_raw[PIN_VS_ON]  = vs_above_on;
  assign pin_raw[PIN_VS_OFF] = vs_above_off;
  assign pin_raw[PIN_OV]     = overvoltage_detector;
  assign pin_raw[PIN_UV]     = undervoltage_detector;
  assign pin_raw[PIN_OCF]    = overcurrent_fault;
  assign pin_raw[PIN_CM]     = current_mode_comparator;
  assign pin_raw[PIN_OCUT]   = overcurrent_cutoff;
  assign pin_raw[PIN_OMIT]   = omission_overcurrent_comparator;
  assign pin_raw[PIN_SKIP]   = pulse_skip_input;
  assign pin_raw[PIN_SYNC]   = sync_in;

  pfsc_sync2 #(.W(NPIN)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_raw),
    .dout    (pin_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= pin_s[PIN_SYNC];
    end
  end
  assign sync_fall = sync_d_r & ~pin_s[PIN_SYNC];

  pfsc_clksel u_clksel (
    .pclk      (pclk),
    .presetn   (presetn),
    .sync_edge (sync_d_r ^ pin_s[PIN_SYNC]),
    .ext_mode  (ext_mode),
    .settled   (settled)
  );

  // frequency generator: rising phase first, then falling phase
  assign fg_rise_ph = (fg_cnt_r < FG_RISE_CYC);
  assign fg_fall    = (fg_cnt_r == FG_RISE_CYC);
  assign fg_wrap    = (fg_cnt_r == FG_PERIOD_CYC - 1'b1);

  // a slave restarts its period at the master's half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fg_cnt_r <= '0;
    end else if ((ext_mode && sync_fall) || fg_wrap) begin
      fg_cnt_r <= '0;
    end else begin
      fg_cnt_r <= fg_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= (fg_cnt_r < FG_HALF_CYC);
    end
  end

  // ramp held at its minimum in the rising phase, climbs afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_r <= RAMP_MIN_LVL;
    end else if (fg_rise_ph) begin
      ramp_r <= RAMP_MIN_LVL;
    end else if (ramp_r != '1) begin
      ramp_r <= ramp_r + 1'b1;
    end
  end

  // lower of soft start and regulation reference sets the width
  assign duty_lim = (ss_level_r < duty_ref_r) ? ss_level_r : duty_ref_r;
  assign duty_clr = (ramp_r > duty_lim);
  assign omit_clr = pin_s[PIN_SKIP] & pin_s[PIN_OMIT];
  assign pulse_clr = duty_clr | pin_s[PIN_CM] | pin_s[PIN_OCUT]
                   | omit_clr;

  // clear beats set, so a pending clear drops the whole pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 1'b0;
    end else if (pulse_clr || fg_rise_ph) begin
      pulse_r <= 1'b0;
    end else if (fg_fall) begin
      pulse_r <= 1'b1;
    end
  end

  // supply hysteresis: on above upper level, off below lower level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_ok_r <= 1'b0;
    end else if (!pin_s[PIN_VS_OFF]) begin
      supply_ok_r <= 1'b0;
    end else if (pin_s[PIN_VS_ON]) begin
      supply_ok_r <= 1'b1;
    end
  end

  assign fault_any = pin_s[PIN_OV] | pin_s[PIN_UV] | pin_s[PIN_OCF]
                   | ~supply_ok_r;
  assign restart_req = (ss_level_r < RESTART_LVL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ok_r <= 1'b0;
    end else if (fault_any) begin
      fault_ok_r <= 1'b0;
    end else if (restart_req) begin
      fault_ok_r <= 1'b1;
    end
  end

  // discharge until the restart level is reached after any fault
  assign ss_dis = fault_any | ~fault_ok_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_div_r <= '0;
    end else if (ss_dis || ss_div_r == ss_div_cfg_r) begin
      ss_div_r <= '0;
    end else begin
      ss_div_r <= ss_div_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_level_r <= '0;
    end else if (ss_dis) begin
      ss_level_r <= (ss_level_r > SS_DIS_STEP) ?
                    ss_level_r - SS_DIS_STEP : '0;
    end else if (ss_div_r == ss_div_cfg_r && ss_level_r < SS_MAX_LVL) begin
      ss_level_r <= ss_level_r + 1'b1;
    end
  end

  // the gate flop is the only path to the pin
  assign gate_nxt = supply_ok_r & fault_ok_r & ~fault_any & pulse_r
                  & ~pulse_clr & ~fg_rise_ph;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_drive_out <= 1'b0;
    end else begin
      gate_drive_out <= gate_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_ext     <= 1'b0;
      timing_settled <= 1'b0;
    end else begin
      timing_ext     <= ext_mode;
      timing_settled <= settled;
    end
  end

  // APB slave: answer in the first access cycle
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign addr_hit  = (paddr == OFS_DUTY) || (paddr == OFS_SSDIV)
                  || (paddr == OFS_STATUS);

  always_comb begin
    rd_val = '0;
    unique case (paddr)
      OFS_DUTY:   rd_val[LVL_W-1:0] = duty_ref_r;
      OFS_SSDIV:  rd_val[LVL_W-1:0] = ss_div_cfg_r;
      OFS_STATUS: begin
        rd_val[ST_SUPPLY]  = supply_ok_r;
        rd_val[ST_FAULTOK] = fault_ok_r;
        rd_val[ST_PULSE]   = pulse_r;
        rd_val[ST_EXT]     = ext_mode;
        rd_val[ST_SETTLED] = settled;
        rd_val[ST_GATE]    = gate_drive_out;
        rd_val[ST_FAULT]   = fault_any;
        rd_val[ST_SS_LSB +: LVL_W] = ss_level_r;
      end
      default:    rd_val = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      prdata  <= (apb_setup && !pwrite) ? rd_val : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ref_r   <= DUTY_RST;
      ss_div_cfg_r <= SSDIV_RST;
    end else if (apb_wr && paddr == OFS_DUTY) begin
      duty_ref_r   <= pwdata[LVL_W-1:0];
    end else if (apb_wr && paddr == OFS_SSDIV) begin
      ss_div_cfg_r <= pwdata[LVL_W-1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_no_supply;
    !supply_ok_r |=> !gate_drive_out;
  endproperty
  a_no_supply: assert property (p_no_supply)
    else $error("gate high without valid supply");

  property p_hyst;
    supply_ok_r && pin_s[PIN_VS_OFF] |=> supply_ok_r;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("supply valid dropped above turn-off level");

  property p_set;
    fg_fall && !pulse_clr |=> pulse_r;
  endproperty
  a_set: assert property (p_set)
    else $error("pulse latch not set on generator edge");

  property p_clr;
    pulse_clr |=> !pulse_r ##1 !gate_drive_out;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear did not inhibit pulse");

  property p_duty;
    !fg_rise_ph && ramp_r > duty_lim |=> !gate_drive_out;
  endproperty
  a_duty: assert property (p_duty)
    else $error("gate high with ramp above duty limit");

  property p_restart;
    !fault_any && restart_req |=> fault_ok_r;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart request not taken");

  property p_fault;
    fault_any |=> !fault_ok_r && !gate_drive_out;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault did not force gate low");

  property p_gradual;
    fault_ok_r && !fault_any |=>
      ss_level_r <= LVL_W'($past(ss_level_r) + 1'b1);
  endproperty
  a_gradual: assert property (p_gradual)
    else $error("soft start rose in a step");

  property p_cause;
    gate_drive_out |-> $past(pulse_r) && $past(fault_ok_r)
                       && $past(supply_ok_r);
  endproperty
  a_cause: assert property (p_cause)
    else $error("gate high without all enables");

  property p_discharge;
    fault_any && ss_level_r != '0 |=> ss_level_r < $past(ss_level_r);
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("soft start not discharging on fault");

  property p_zero_duty;
    ss_level_r < RAMP_MIN_LVL |=> !gate_drive_out;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("gate high with soft start below ramp minimum");

  property p_min_low;
    fg_rise_ph |=> !gate_drive_out;
  endproperty
  a_min_low: assert property (p_min_low)
    else $error("gate high in rising phase");

  property p_skip;
    omit_clr[*2] |=> !gate_drive_out;
  endproperty
  a_skip: assert property (p_skip)
    else $error("pulse not omitted");

  property p_period;
    fg_wrap |=> fg_cnt_r == '0;
  endproperty
  a_period: assert property (p_period)
    else $error("generator period not restarted");

  c_pulse: cover property ($rose(gate_drive_out) ##[1:100]
                           $fell(gate_drive_out));
  c_fault_recover: cover property ($fell(fault_ok_r) ##[1:1000]
                                   $rose(fault_ok_r));
  c_ext: cover property ($rose(timing_ext));
endmodule

// *** verification/pfsc_gate_model.sv ***
// Purpose: current-sense network behind the external power gate
// Assumes: sense level builds while the gate conducts, drops when off
// Notes:   trip of zero keeps the comparator quiet
`timescale 1ns/1ps
module pfsc_gate_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       gate_drive_out,
  input  wire logic [7:0] trip,
  output logic            current_mode_comparator
);
  logic [7:0] on_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r <= 8'h00;
    end else begin
      on_r <= gate_drive_out ? on_r + 8'h01 : 8'h00;
    end
  end
  // inductor current rises only while the switch is on
  assign current_mode_comparator = (trip != 8'h00) && (on_r >= trip);
endmodule

// *** verification/tb_pwm_fault_softstart_ctrl.sv ***
// Purpose: self-checking bench for the gate pulse and fault control
// Assumes: gate widths compared to each other and to bounds; sync width exact
// Notes:   a bench process plays the master's sync output
`timescale 1ns/1ps
module tb_pwm_fault_softstart_ctrl;
  import pfsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, trip;
  logic [31:0] pwdata, prdata, rd;
  logic        vs_on, vs_off, cm, ocut, omit, skip, sync_in, srun;
  logic [2:0]  flt;
  logic        gate, sync_out, t_ext, t_set;
  int          n_errors, n_tests, cyc, scnt, w, wt, w0, wss, wl, wh, i;
  time         t0, t1;

  pfsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vs_above_on(vs_on), .vs_above_off(vs_off),
    .overvoltage_detector(flt[0]), .undervoltage_detector(flt[1]),
    .overcurrent_fault(flt[2]), .current_mode_comparator(cm),
    .overcurrent_cutoff(ocut), .omission_overcurrent_comparator(omit),
    .pulse_skip_input(skip), .sync_in(sync_in), .gate_drive_out(gate),
    .sync_out(sync_out), .timing_ext(t_ext), .timing_settled(t_set));
  pfsc_gate_model u_sense (.pclk(pclk), .presetn(presetn),
    .gate_drive_out(gate), .trip(trip), .current_mode_comparator(cm));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // master sync: high for the first half of a 100-cycle period
  always @(posedge pclk) begin
    scnt <= (scnt == 99) ? 0 : scnt + 1;
    sync_in <= srun && (scnt < 50);
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  task end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) chk(0, 1);
  endtask
  task rise();
    wt = 0;
    while (gate !== 1'b1 && wt < 600) begin
      @(posedge pclk);
      wt++;
    end
  endtask
  // width of the next whole pulse; zero when none comes
  task meas();
    w = 0;
    while (gate === 1'b1 && w < 200) begin
      @(posedge pclk);
      w++;
    end
    rise();
    t1 = $time;
    w = 0;
    while (gate === 1'b1 && w < 200) begin
      @(posedge pclk);
      w++;
    end
  endtask
  task fall_in(input int lim);
    wt = 0;
    while (gate === 1'b1 && wt < 10) begin
      @(posedge pclk);
      wt++;
    end
    chk(wt <= lim, 1);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, trip} = '0;
    // cyc, scnt and sync_in are owned by their clocked processes
    {vs_on, vs_off, ocut, omit, skip, flt, srun} = '0;
    {presetn, n_errors, n_tests} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_DUTY, 0);
    chk(rd, 32'h0000_0080);
    apb(0, OFS_SSDIV, 0);
    chk(rd, 32'h0000_0010);
    apb(0, 8'h0C, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, 8'h0C, 32'h0000_0055);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, OFS_SSDIV, 32'hFFFF_FF03);
    apb(0, OFS_SSDIV, 0);
    chk(rd, 32'h0000_0003);
    apb(1, OFS_STATUS, 32'hFFFF_FFFF);
    apb(0, OFS_STATUS, 0);
    chk(rd & 32'h0000_0027, 0);
    repeat (100) @(posedge pclk);
    chk(gate, 0);
    vs_on <= 1'b1;
    vs_off <= 1'b1;
    meas();
    chk(wt > 300, 1);
    w0 = w;
    for (i = 0; i < 12; i++) begin
      wl = w;
      meas();
      chk(w >= wl, 1);
    end
    wss = w;
    chk(wss > w0, 1);
    t0 = t1;
    meas();
    chk(32'(t1 - t0), 32'd10000);
    apb(1, OFS_DUTY, 32'h0000_0060);
    meas(); meas(); wl = w;
    apb(1, OFS_DUTY, 32'h0000_00A0);
    meas(); meas(); wh = w;
    chk(wl < wss && wss < wh, 1);
    apb(1, OFS_DUTY, 32'h0000_00FF);
    meas(); meas();
    chk(w > wh && w < 90, 1);
    apb(1, OFS_DUTY, 32'h0000_0040);
    meas(); meas();
    chk(w, 0);
    apb(1, OFS_DUTY, 32'h0000_0080);
    meas();
    trip <= 8'h05;
    meas(); meas();
    chk(w > 0 && w < 12, 1);
    trip <= 8'h00;
    ocut <= 1'b1;
    meas(); meas();
    chk(w, 0);
    ocut <= 1'b0;
    skip <= 1'b1;
    meas(); meas();
    chk(w > 0, 1);
    omit <= 1'b1;
    meas(); meas();
    chk(w, 0);
    {omit, skip} <= 2'b00;
    for (i = 0; i < 3; i++) begin
      rise();
      flt <= 3'b001 << i;
      fall_in(4);
      repeat (100) @(posedge pclk);
      apb(0, OFS_STATUS, 0);
      chk(rd & 32'h0000_FF62, 32'h0000_0040);
      flt <= 3'b000;
      meas();
      chk(w > 0 && w < wss, 1);
      repeat (1000) @(posedge pclk);
    end
    rise();
    vs_on <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk(rd[0], 1);
    rise();
    vs_off <= 1'b0;
    // the supply-valid flop adds one edge to the fault path
    fall_in(5);
    apb(0, OFS_STATUS, 0);
    chk(rd[0], 0);
    vs_on <= 1'b1;
    vs_off <= 1'b1;
    repeat (1100) @(posedge pclk);
    // start on a rising edge of sync_out, not inside a high phase
    wt = 0;
    while (sync_out === 1'b1 && wt < 100) begin
      @(posedge pclk);
      wt++;
    end
    while (sync_out !== 1'b1 && wt < 200) begin
      @(posedge pclk);
      wt++;
    end
    w = 0;
    while (sync_out === 1'b1 && w < 200) begin
      @(posedge pclk);
      w++;
    end
    chk(w, 50);
    chk(t_ext, 0);
    srun <= 1'b1;
    repeat (800) @(posedge pclk);
    chk({t_ext, t_set}, 2'b10);
    repeat (500) @(posedge pclk);
    chk(t_set, 1);
    while (scnt != 50) @(posedge pclk);
    rise();
    chk(wt >= 11 && wt <= 18, 1);
    srun <= 1'b0;
    repeat (500) @(posedge pclk);
    chk(t_ext, 0);
    end_of_test();
  end
endmodule
